// ---- verilog/csst_defs.svh ----
// Constants for the charge sequencer, status and watchdog block.
`ifndef CSST_DEFS_SVH
`define CSST_DEFS_SVH
`define CSST_REG_CTRL          8'h00
`define CSST_REG_STEP          8'h04
`define CSST_REG_STATUS        8'h08
`define CSST_REG_CURRENT       8'h0c
`define CSST_CTRL_RST          1'h1
`define CSST_STEP_RST          11'h00a
`define CSST_ST_TCF_BIT        8
`define CSST_ST_THERM_BIT      9
`define CSST_ST_RUN_BIT        10
`define CSST_ST_PIN_LSB        12
`define CSST_CUR_TERM_LSB      16
`define CSST_CLK_PERIOD_NS     10
`define CSST_TICK_NS           10000000
`define CSST_TICK_CYC          (`CSST_TICK_NS / `CSST_CLK_PERIOD_NS)
`define CSST_TICKS_PER_S       (1000000000 / `CSST_TICK_NS)
`define CSST_TRICKLE_TO_MIN    25
`define CSST_TRICKLE_TO_TICKS  (`CSST_TRICKLE_TO_MIN * 60 * `CSST_TICKS_PER_S)
`define CSST_FAST_TO_H         3
`define CSST_FAST_TO_TICKS     (`CSST_FAST_TO_H * 3600 * `CSST_TICKS_PER_S)
`define CSST_VHOLD_TO_H        3
`define CSST_VHOLD_TO_TICKS    (`CSST_VHOLD_TO_H * 3600 * `CSST_TICKS_PER_S)
`define CSST_THERM_MS          1500
`define CSST_THERM_TICKS       (`CSST_THERM_MS * 1000000 / `CSST_TICK_NS)
`define CSST_BLINK_HZ          1
`define CSST_BLINK_HALF_TICKS  (`CSST_TICKS_PER_S / (2 * `CSST_BLINK_HZ))
`define CSST_FLASH_HALF_MS     250
`define CSST_FLASH_HALF_TICKS  (`CSST_FLASH_HALF_MS * 1000000 / `CSST_TICK_NS)
`define CSST_TRICKLE_DIV       10
`define CSST_TERM_DEF_DIV      10
`define CSST_THERM_PCT         28
`define CSST_TERM_UA           15
`define CSST_TERM_DIV_UV       2000000
`endif

// ---- verilog/csst_pkg.sv ----
// Types shared by the charge sequencer block.
package csst_pkg;
   typedef enum logic [6:0] {
      ST_OFF     = 7'h01,
      ST_NOBAT   = 7'h02,
      ST_TRICKLE = 7'h04,
      ST_CHOLD   = 7'h08,
      ST_VHOLD   = 7'h10,
      ST_SLEEP   = 7'h20,
      ST_FAULT   = 7'h40
   } csst_state_e;
   typedef struct packed {
      logic present;
      logic below_min;
      logic at_reg;
      logic below_rch;
   } csst_sense_s;
   typedef struct packed {
      logic o;
      logic oe;
   } csst_od_s;
endpackage

// ---- verilog/csst_charge_seq.sv ----
// Charge sequencer with status pins, thermal loop, watchdog and AHB-Lite registers.
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "csst_defs.svh"
module csst_charge_seq import csst_pkg::*; #(
   parameter int unsigned CUR_W      = 11,
   parameter int unsigned RES_W      = 20,
   parameter int unsigned TICK_CYC   = `CSST_TICK_CYC,
   parameter int unsigned TRICKLE_TO = `CSST_TRICKLE_TO_TICKS,
   parameter int unsigned FAST_TO    = `CSST_FAST_TO_TICKS,
   parameter int unsigned VHOLD_TO   = `CSST_VHOLD_TO_TICKS,
   parameter int unsigned THERM_PER  = `CSST_THERM_TICKS,
   parameter int unsigned BLINK_HALF = `CSST_BLINK_HALF_TICKS,
   parameter int unsigned FLASH_HALF = `CSST_FLASH_HALF_TICKS
) (
   // Clock and reset.
   input  wire logic              core_clk,
   input  wire logic              rst,
   // AHB-Lite slave.
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Supply, enable and analog comparators.
   input  wire logic              en,
   input  wire logic              supply_ok,
   input  wire logic              timer_capacitor_pin_grounded,
   input  wire logic              die_hot,
   input  wire csst_sense_s       battery_sense_pin,
   input  wire logic              term_res_fitted,
   input  wire logic [RES_W-1:0]  term_res_ohms,
   input  wire logic [CUR_W-1:0]  fast_charge_current,
   input  wire logic [CUR_W-1:0]  charge_current_meas,
   // Charger power stage command.
   output logic                   charge_enable,
   output logic      [CUR_W-1:0]  charge_current_set,
   // Open-drain status pins.
   output csst_od_s               charge_indicator_a,
   input  wire logic              charge_indicator_a_i,
   output csst_od_s               charge_indicator_b,
   input  wire logic              charge_indicator_b_i,
   output csst_od_s               supply_present_n,
   input  wire logic              supply_present_n_i
);
   csst_state_e       st_q;
   csst_state_e       st_d;
   csst_state_e       qual;
   logic [31:0]       tick_cnt_q;
   logic              tick;
   logic [31:0]       ph_cnt_q;
   logic              ph_clr;
   logic              timer_en;
   logic              to_hit;
   logic              charging;
   logic              run;
   logic              tc_fault_q;
   logic              term_hit;
   logic [47:0]       term_prod;
   logic [CUR_W-1:0]  termination_current;
   logic [CUR_W-1:0]  thermal_reduced_current;
   logic [CUR_W-1:0]  trickle_current;
   logic              therm_q;
   logic [CUR_W-1:0]  therm_cur_q;
   logic [31:0]       therm_cnt_q;
   logic              therm_enter;
   logic              therm_step;
   logic [CUR_W:0]    therm_up;
   logic [CUR_W-1:0]  target_d;
   logic [31:0]       flash_cnt_q;
   logic [31:0]       flash_lim;
   logic              flash_ph_q;
   logic              a_on_d;
   logic              b_on_d;
   logic              a_oe_q;
   logic              b_oe_q;
   logic              sup_oe_q;
   logic              ap;
   logic              wr_q;
   logic [7:0]        wa_q;
   logic              ctrl_q;
   logic              ctrl_d;
   logic [CUR_W-1:0]  step_q;
   logic [CUR_W-1:0]  step_d;
   logic [31:0]       status_w;
   logic [31:0]       current_w;
   logic [31:0]       rd_d;
   logic [31:0]       hrdata_q;
   logic              chg_en_q;
   logic [CUR_W-1:0]  chg_cur_q;

   // Common 10 ms timebase; every slow timer counts these ticks.
   assign tick = (tick_cnt_q == TICK_CYC - 1);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 32'h0;
      end else begin
         tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      end
   end

   // Termination threshold, from the default ratio or the set resistor.
   assign term_prod = 48'(fast_charge_current) * 48'(term_res_ohms) * 48'(`CSST_TERM_UA);
   assign termination_current = term_res_fitted ?
      CUR_W'(term_prod / 48'(`CSST_TERM_DIV_UV)) :
      CUR_W'(fast_charge_current / CUR_W'(`CSST_TERM_DEF_DIV));
   assign term_hit = (charge_current_meas <= termination_current);
   assign trickle_current = CUR_W'(fast_charge_current / CUR_W'(`CSST_TRICKLE_DIV));
   assign thermal_reduced_current =
      CUR_W'((32'(fast_charge_current) * 32'(`CSST_THERM_PCT)) / 32'd100);

   // Enable cycling or supply loss restarts the charge sequence from ST_OFF, including a held fault.
   assign run = en & supply_ok & ctrl_q;
   assign timer_en = ~timer_capacitor_pin_grounded;
   assign charging = (st_q == ST_TRICKLE) | (st_q == ST_CHOLD) | (st_q == ST_VHOLD);
   assign to_hit = timer_en & (
      ((st_q == ST_TRICKLE) & (ph_cnt_q >= TRICKLE_TO)) |
      ((st_q == ST_CHOLD) & (ph_cnt_q >= FAST_TO)) |
      ((st_q == ST_VHOLD) & (ph_cnt_q >= VHOLD_TO)));
   assign qual = !battery_sense_pin.present ? ST_NOBAT :
                 battery_sense_pin.below_min ? ST_TRICKLE :
                 battery_sense_pin.at_reg ? ST_VHOLD : ST_CHOLD;

   always_comb begin
      st_d = st_q;
      if (!run) begin
         st_d = ST_OFF;
      end else begin
         case (st_q)
            ST_OFF: begin
               st_d = qual;
            end
            ST_NOBAT: begin
               if (battery_sense_pin.present) st_d = qual;
            end
            ST_TRICKLE: begin
               if (to_hit) st_d = ST_FAULT;
               else if (!battery_sense_pin.present) st_d = ST_NOBAT;
               else if (!battery_sense_pin.below_min) st_d = ST_CHOLD;
            end
            ST_CHOLD: begin
               if (to_hit) st_d = ST_FAULT;
               else if (!battery_sense_pin.present) st_d = ST_NOBAT;
               else if (battery_sense_pin.at_reg) st_d = ST_VHOLD;
            end
            ST_VHOLD: begin
               if (to_hit) st_d = ST_FAULT;
               else if (!battery_sense_pin.present) st_d = ST_NOBAT;
               else if (term_hit) st_d = ST_SLEEP;
            end
            ST_SLEEP: begin
               if (!battery_sense_pin.present) st_d = ST_NOBAT;
               else if (battery_sense_pin.below_rch) st_d = qual;
            end
            ST_FAULT: begin
               st_d = ST_FAULT;
            end
            default: begin
               st_d = ST_OFF;
            end
         endcase
      end
   end

   // The trickle timer keeps running into current-hold so both phases share one budget.
   assign ph_clr = (st_d != st_q) & ~((st_q == ST_TRICKLE) & (st_d == ST_CHOLD));
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_OFF;
         ph_cnt_q <= 32'h0;
         tc_fault_q <= 1'b0;
      end else begin
         st_q <= st_d;
         if (ph_clr) ph_cnt_q <= 32'h0;
         else if (charging && timer_en && tick) ph_cnt_q <= ph_cnt_q + 32'h1;
         if (st_q == ST_TRICKLE && st_d == ST_FAULT) tc_fault_q <= 1'b1;
         else if (st_q == ST_OFF) tc_fault_q <= 1'b0;
      end
   end

   // Thermal loop: one cut on entry, then stepped recovery at each recheck that finds the die cool.
   assign therm_enter = (st_q == ST_CHOLD) & die_hot & ~therm_q;
   assign therm_step = therm_q & tick & (therm_cnt_q >= THERM_PER - 1);
   assign therm_up = {1'b0, therm_cur_q} + {1'b0, step_q};
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         therm_q <= 1'b0;
         therm_cur_q <= '0;
         therm_cnt_q <= 32'h0;
      end else if (st_q != ST_CHOLD) begin
         therm_q <= 1'b0;
         therm_cnt_q <= 32'h0;
      end else if (therm_enter) begin
         therm_q <= 1'b1;
         therm_cur_q <= thermal_reduced_current;
         therm_cnt_q <= 32'h0;
      end else if (therm_step) begin
         therm_cnt_q <= 32'h0;
         // Still hot means equilibrium: hold the present level.
         if (!die_hot && therm_up >= {1'b0, fast_charge_current}) begin
            therm_q <= 1'b0;
            therm_cur_q <= fast_charge_current;
         end else if (!die_hot) begin
            therm_cur_q <= therm_up[CUR_W-1:0];
         end
      end else if (therm_q && tick) begin
         therm_cnt_q <= therm_cnt_q + 32'h1;
      end
   end

   always_comb begin
      case (st_q)
         ST_TRICKLE: target_d = trickle_current;
         ST_CHOLD:   target_d = therm_q ? therm_cur_q : fast_charge_current;
         ST_VHOLD:   target_d = fast_charge_current;
         default:    target_d = '0;
      endcase
   end

   // One blink counter serves both rates; in ST_NOBAT both indications blink together.
   assign flash_lim = (st_q == ST_NOBAT) ? FLASH_HALF : BLINK_HALF;
   assign a_on_d = charging |
                   ((st_q == ST_NOBAT) & flash_ph_q) |
                   ((st_q == ST_FAULT) & tc_fault_q & flash_ph_q);
   assign b_on_d = (st_q == ST_SLEEP) | ((st_q == ST_NOBAT) & flash_ph_q);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flash_cnt_q <= 32'h0;
         flash_ph_q <= 1'b0;
         a_oe_q <= 1'b0;
         b_oe_q <= 1'b0;
         sup_oe_q <= 1'b0;
         chg_en_q <= 1'b0;
         chg_cur_q <= '0;
      end else begin
         if (tick && flash_cnt_q >= flash_lim - 1) begin
            flash_cnt_q <= 32'h0;
            flash_ph_q <= ~flash_ph_q;
         end else if (tick) begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
         end
         a_oe_q <= a_on_d;
         b_oe_q <= b_on_d;
         sup_oe_q <= supply_ok;
         chg_en_q <= charging;
         chg_cur_q <= target_d;
      end
   end
   // Open-drain: the pin is only ever pulled low, never driven high.
   assign charge_indicator_a = '{o: 1'b0, oe: a_oe_q};
   assign charge_indicator_b = '{o: 1'b0, oe: b_oe_q};
   assign supply_present_n = '{o: 1'b0, oe: sup_oe_q};
   assign charge_enable = chg_en_q;
   assign charge_current_set = chg_cur_q;

   // AHB-Lite slave, zero wait states; reads use next values so write-then-read is fresh.
   assign ap = hsel & hready & htrans[1] & (hsize == 3'b010);
   assign ctrl_d = (wr_q && wa_q == `CSST_REG_CTRL) ? hwdata[0] : ctrl_q;
   assign step_d = (wr_q && wa_q == `CSST_REG_STEP) ? hwdata[CUR_W-1:0] : step_q;
   assign status_w = 32'(st_q) |
                     (32'(tc_fault_q) << `CSST_ST_TCF_BIT) |
                     (32'(therm_q) << `CSST_ST_THERM_BIT) |
                     (32'(run) << `CSST_ST_RUN_BIT) |
                     (32'({supply_present_n_i, charge_indicator_b_i, charge_indicator_a_i})
                        << `CSST_ST_PIN_LSB);
   assign current_w = 32'(chg_cur_q) | (32'(termination_current) << `CSST_CUR_TERM_LSB);
   assign rd_d = (haddr[7:0] == `CSST_REG_CTRL)    ? 32'(ctrl_d) :
                 (haddr[7:0] == `CSST_REG_STEP)    ? 32'(step_d) :
                 (haddr[7:0] == `CSST_REG_STATUS)  ? status_w :
                 (haddr[7:0] == `CSST_REG_CURRENT) ? current_w : 32'h0;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_q <= 1'b0;
         wa_q <= 8'h0;
         ctrl_q <= `CSST_CTRL_RST;
         step_q <= CUR_W'(`CSST_STEP_RST);
         hrdata_q <= 32'h0;
      end else begin
         wr_q <= ap & hwrite;
         wa_q <= haddr[7:0];
         ctrl_q <= ctrl_d;
         step_q <= step_d;
         if (ap && !hwrite) hrdata_q <= rd_d;
      end
   end
   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_enter_vhold;
      (st_q != ST_VHOLD) ##1 (st_q == ST_VHOLD);
   endsequence
   sequence s_vhold_done;
      (st_q == ST_VHOLD) && run && battery_sense_pin.present && term_hit && !to_hit;
   endsequence
   sequence s_sleep_wake;
      (st_q == ST_SLEEP) && run && battery_sense_pin.present && battery_sense_pin.below_rch;
   endsequence

   AST_TERM_SLEEP: assert property (s_vhold_done |=> st_q == ST_SLEEP)
      else $error("termination did not enter sleep");
   AST_RECHARGE: assert property (s_sleep_wake |=>
      (st_q == ST_TRICKLE || st_q == ST_CHOLD || st_q == ST_VHOLD))
      else $error("recharge did not restart charging");
   AST_SLEEP_HOLD: assert property ((st_q == ST_SLEEP) && run &&
      battery_sense_pin.present && !battery_sense_pin.below_rch |=> st_q == ST_SLEEP)
      else $error("left sleep without recharge condition");
   AST_LED_CHG: assert property (charging |=>
      charge_indicator_a.oe && !charge_indicator_b.oe)
      else $error("charging indication wrong");
   AST_LED_DONE: assert property ((st_q == ST_SLEEP) |=>
      !charge_indicator_a.oe && charge_indicator_b.oe)
      else $error("complete indication wrong");
   AST_NOBAT_FLASH: assert property ((st_q == ST_NOBAT) |=>
      (charge_indicator_a.oe == $past(flash_ph_q)) &&
      (charge_indicator_b.oe == $past(flash_ph_q)))
      else $error("no-battery flash wrong");
   AST_SUPPLY: assert property (1'b1 |=>
      (supply_present_n.oe == $past(supply_ok)) && !supply_present_n.o)
      else $error("supply indication wrong");
   AST_THERM_CUT: assert property (therm_enter |=>
      therm_q && (therm_cur_q == $past(thermal_reduced_current)))
      else $error("thermal cut level wrong");
   AST_TRICKLE_CC: assert property ((st_q == ST_TRICKLE) && run && !to_hit &&
      battery_sense_pin.present && !battery_sense_pin.below_min |=> st_q == ST_CHOLD)
      else $error("trickle did not advance");
   AST_VHOLD_CLR: assert property (s_enter_vhold |-> ph_cnt_q == 32'h0)
      else $error("phase timer not cleared");
   AST_TIMER_OFF: assert property (timer_capacitor_pin_grounded |-> !to_hit)
      else $error("timeout while timer disabled");
   AST_FAULT_HOLD: assert property ((st_q == ST_FAULT) && run |=> st_q == ST_FAULT)
      else $error("fault released early");
   AST_OFF_RESTART: assert property (!run |=> st_q == ST_OFF)
      else $error("disable did not reset control");
   AST_TC_BLINK: assert property ((st_q == ST_FAULT) && tc_fault_q |=>
      charge_indicator_a.oe == $past(flash_ph_q))
      else $error("trickle timeout blink wrong");
endmodule // csst_charge_seq

// ---- verification/csst_led_model.sv ----
// Pull-up and LED load model for the open-drain status pins.
`timescale 1ns/1ps
module csst_led_model import csst_pkg::*; (
   // Pins as driven by the block.
   input  wire csst_od_s a,
   input  wire csst_od_s b,
   input  wire csst_od_s sup,
   // Resolved pin levels.
   output logic          a_lvl,
   output logic          b_lvl,
   output logic          sup_lvl
);
   // A released pin rests at the LED anode supply through the pull-up.
   assign a_lvl   = a.oe ? a.o : 1'b1;
   assign b_lvl   = b.oe ? b.o : 1'b1;
   assign sup_lvl = sup.oe ? sup.o : 1'b1;
endmodule // csst_led_model

// ---- verification/charge_sequencer_status_timer_bench.sv ----
// Self-checking bench for the charge sequencer block.
`timescale 1ns/1ps
module charge_sequencer_status_timer_bench;
   import csst_pkg::*;
   logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, rd_dp = 0, p;
   logic en = 0, supply_ok = 1, tgnd = 0, die_hot = 0, tfit = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q_exp[$], q_msk[$];
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   csst_sense_s sense = 4'hc;
   logic [19:0] ohms = 0;
   logic [10:0] fast = 0, meas = 0, cur_set, f10, f28, thr;
   logic hreadyout, hresp, chg_en, lv_a, lv_b, lv_s;
   csst_od_s od_a, od_b, od_s;
   logic [7:0] lf = 8'h50;
   int n_fail = 0, num_checks = 0, cyc = 0;

   csst_charge_seq #(.TICK_CYC(10), .TRICKLE_TO(20), .FAST_TO(40), .VHOLD_TO(30),
      .THERM_PER(3), .BLINK_HALF(2), .FLASH_HALF(3)) i_dut (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .en(en),
      .supply_ok(supply_ok), .timer_capacitor_pin_grounded(tgnd), .die_hot(die_hot),
      .battery_sense_pin(sense), .term_res_fitted(tfit), .term_res_ohms(ohms),
      .fast_charge_current(fast), .charge_current_meas(meas),
      .charge_enable(chg_en), .charge_current_set(cur_set),
      .charge_indicator_a(od_a), .charge_indicator_a_i(lv_a),
      .charge_indicator_b(od_b), .charge_indicator_b_i(lv_b),
      .supply_present_n(od_s), .supply_present_n_i(lv_s));
   csst_led_model i_led (.a(od_a), .b(od_b), .sup(od_s), .a_lvl(lv_a), .b_lvl(lv_b),
      .sup_lvl(lv_s));

   always #5 core_clk = ~core_clk;

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic [31:0] st(input logic [6:0] s, input logic [2:0] pn,
      input logic [2:0] f);
      return {17'h0, pn, 1'b0, f, 1'b0, s};
   endfunction
   task automatic wrap_up;
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // The address phase is held until hready is seen, so wait states are tolerated.
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rd_dp <= ~w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      q_exp.push_back(e);
      q_msk.push_back(m);
      ahb(a, 1'b0, 32'h0);
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (rd_dp && hreadyout === 1'b1 && q_exp.size() > 0)
         check("hrdata", q_exp.pop_front(), hrdata & q_msk.pop_front());
      if (cyc == 20000) begin
         n_fail++;
         wrap_up;
      end
   end

   initial begin
      fast = 11'd100 + 11'(int'(lf) * 3);
      lf = lfsr(lf);
      ohms = 20'd20000 + 20'(int'(lf) * 100);
      f10 = fast / 11'd10;
      f28 = 11'(int'(fast) * 28 / 100);
      thr = 11'(int'(fast) * int'(ohms) * 15 / 2000000);
      tick(4);
      rst <= 1'b0;
      tick(1);
      rd(8'h00, 32'h1);
      rd(8'h04, 32'ha);
      hsize <= 3'h0;
      ahb(8'h00, 1'b1, 32'h0);
      hsize <= 3'h2;
      rd(8'h00, 32'h1);
      ahb(8'h10, 1'b1, 32'hffffffff);
      rd(8'h10, 32'h0);
      rd(8'h08, st(ST_OFF, 3'h3, 3'h0));
      ahb(8'h00, 1'b1, 32'h0);
      en <= 1'b1;
      tick(5);
      rd(8'h08, st(ST_OFF, 3'h3, 3'h0));
      ahb(8'h00, 1'b1, 32'h1);
      tick(5);
      rd(8'h08, st(ST_TRICKLE, 3'h2, 3'h4));
      rd(8'h0c, {5'h0, f10, 5'h0, f10});
      sense.below_min <= 1'b0;
      tick(5);
      rd(8'h08, st(ST_CHOLD, 3'h2, 3'h4));
      rd(8'h0c, {5'h0, f10, 5'h0, fast});
      die_hot <= 1'b1;
      tick(5);
      rd(8'h08, st(ST_CHOLD, 3'h2, 3'h6));
      rd(8'h0c, {5'h0, f10, 5'h0, f28});
      ahb(8'h04, 1'b1, 32'h7ff);
      die_hot <= 1'b0;
      tick(80);
      rd(8'h08, st(ST_CHOLD, 3'h2, 3'h4));
      rd(8'h0c, {5'h0, f10, 5'h0, fast});
      tfit <= 1'b1;
      sense.at_reg <= 1'b1;
      meas <= fast;
      tick(5);
      rd(8'h08, st(ST_VHOLD, 3'h2, 3'h4));
      rd(8'h0c, {5'h0, thr, 5'h0, fast});
      meas <= thr + 11'd1;
      tick(5);
      rd(8'h08, st(ST_VHOLD, 3'h2, 3'h4));
      meas <= thr;
      tick(5);
      rd(8'h08, st(ST_SLEEP, 3'h1, 3'h4));
      meas <= fast;
      tick(20);
      rd(8'h08, st(ST_SLEEP, 3'h1, 3'h4));
      sense.below_rch <= 1'b1;
      tick(5);
      rd(8'h08, st(ST_VHOLD, 3'h2, 3'h4));
      sense.below_rch <= 1'b0;
      tgnd <= 1'b1;
      tick(400);
      rd(8'h08, st(ST_VHOLD, 3'h2, 3'h4));
      tgnd <= 1'b0;
      tick(360);
      rd(8'h08, st(ST_FAULT, 3'h3, 3'h4));
      sense.at_reg <= 1'b0;
      sense.below_min <= 1'b1;
      tick(5);
      rd(8'h08, st(ST_FAULT, 3'h3, 3'h4));
      en <= 1'b0;
      tick(3);
      en <= 1'b1;
      tick(5);
      rd(8'h08, st(ST_TRICKLE, 3'h2, 3'h4));
      tick(260);
      rd(8'h08, st(ST_FAULT, 3'h2, 3'h5), 32'hffffefff);
      @(negedge core_clk) p = od_a.oe;
      repeat (20) @(negedge core_clk);
      check("blink", !p, od_a.oe);
      @(posedge core_clk) en <= 1'b0;
      lf = lfsr(lf);
      f10 = (11'd100 + 11'(int'(lf) * 3)) / 11'd10;
      fast <= 11'd100 + 11'(int'(lf) * 3);
      lf = lfsr(lf);
      ohms <= 20'd20000 + 20'(int'(lf) * 100);
      tick(3);
      thr = 11'(int'(fast) * int'(ohms) * 15 / 2000000);
      en <= 1'b1;
      tick(5);
      rd(8'h0c, {5'h0, thr, 5'h0, f10});
      tick(93);
      sense.below_min <= 1'b0;
      tick(350);
      rd(8'h08, st(ST_FAULT, 3'h3, 3'h4));
      en <= 1'b0;
      sense.present <= 1'b0;
      tick(3);
      en <= 1'b1;
      tick(5);
      rd(8'h08, {25'h0, ST_NOBAT}, 32'h7f);
      @(negedge core_clk) p = od_a.oe;
      check("flash", p, od_b.oe);
      repeat (30) @(negedge core_clk);
      check("flash", !p, od_a.oe);
      @(posedge core_clk) supply_ok <= 1'b0;
      tick(5);
      rd(8'h08, st(ST_OFF, 3'h7, 3'h0));
      tick(3);
      wrap_up;
   end
endmodule // charge_sequencer_status_timer_bench
